// ### core/pmv_core.sv
// Purpose: Program counter, vectoring and fetch for an 8-bit core
// Assumes: Core sequencer supplies step and sleep requests and global interrupt enables
// Notes: One fetch per clock; data port runs independently
//
// Function
// R1 - Program counter is 21 bits wide, addressing two megabytes.
// R2 - Fetch beyond implemented flash returns all-zero word, a no-operation.
// R3 - Small variant has 48 Kbytes flash, large variant 64 Kbytes.
// R4 - After any reset fetching starts at address zero.
// R5 - Exactly two interrupt vectors, at 0008h and 0018h.
// R6 - Interrupt wake with a global enable set loads the vector.
// R7 - That wake pushes the PC to stack top and advances pointer.
// R8 - Interrupt wake sets flag bits identifying the wake source.
// R9 - Program and data memories use separate buses, concurrently.
// R10 - High priority uses 0008h, low priority uses 0018h.
`timescale 1ns/100ps
module pmv_core #(
    parameter bit LARGE_VARIANT = 1'b1,
    parameter int N_SRC = 8
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // Core sequencer
    input wire logic step_in,
    input wire logic sleep_req_in,
    input wire logic high_prio_global_irq_enable_in,
    input wire logic low_prio_global_irq_enable_in,
    // Interrupt sources, level, same clock
    input wire logic [N_SRC-1:0] irq_req_in,
    input wire logic [N_SRC-1:0] irq_en_in,
    input wire logic [N_SRC-1:0] irq_high_in,
    input wire logic [N_SRC-1:0] flag_clr_in,
    // Program bus
    output logic [pmv_pkg::PC_W-1:0] prog_addr_out,
    input wire logic [pmv_pkg::WORD_W-1:0] prog_data_in,
    output logic [pmv_pkg::WORD_W-1:0] instr_out,
    // Data bus, separate from program bus
    input wire logic [pmv_pkg::DATA_ADDR_W-1:0] data_addr_in,
    input wire logic data_rd_in,
    output logic [pmv_pkg::DATA_ADDR_W-1:0] data_addr_out,
    output logic data_rd_out,
    // Vector and stack state
    output logic sleeping_out,
    output logic [pmv_pkg::DATA_W-1:0] stack_top_upper_byte_out,
    output logic [pmv_pkg::DATA_W-1:0] stack_top_high_byte_out,
    output logic [pmv_pkg::DATA_W-1:0] stack_top_low_byte_out,
    output logic [pmv_pkg::SP_W-1:0] hw_stack_pointer_out,
    output logic [N_SRC-1:0] peripheral_irq_flag_regs_out
);
    // R3 flash size per variant
    localparam logic [20:0] FLASH_TOP =
        LARGE_VARIANT ? pmv_pkg::FLASH_BYTES_LARGE : pmv_pkg::FLASH_BYTES_SMALL;

    typedef struct packed {
        pmv_pkg::pmv_mode_e mode;
        logic [pmv_pkg::PC_W-1:0] pc;
        logic [pmv_pkg::PC_W-1:0] tos;
        logic [pmv_pkg::SP_W-1:0] sp;
        logic [N_SRC-1:0] flags;
        logic [pmv_pkg::WORD_W-1:0] instr;
        logic [pmv_pkg::DATA_ADDR_W-1:0] daddr;
        logic drd;
    } pmv_state_s;

    pmv_state_s st_q;
    pmv_state_s st_d;
    logic [pmv_pkg::WORD_W-1:0] gated_word;
    logic [N_SRC-1:0] pend;
    logic any_high;
    logic any_low;
    logic wake;

    // R2 range gate on every fetch
    pmv_fetch_gate #(
        .FLASH_BYTES(FLASH_TOP)
    ) u_gate (
        .addr_in(st_q.pc),
        .flash_data_in(prog_data_in),
        .word_out(gated_word),
        .in_range_out()
    );

    // Pending enabled sources split by priority
    always_comb
    begin
        pend = irq_req_in & irq_en_in;
        any_high = |(pend & irq_high_in);
        any_low = |(pend & ~irq_high_in);
        wake = (st_q.mode == pmv_pkg::PMV_SLEEP) && (any_high || any_low);
    end

    // Next state; sleep request has priority over stepping, wake only from sleep
    always_comb
    begin
        st_d = st_q;
        // R8 flags set by sources, set wins over clear
        st_d.flags = (st_q.flags & ~flag_clr_in) | irq_req_in;
        // R9 data access passes in parallel with fetch
        st_d.daddr = data_addr_in;
        st_d.drd = data_rd_in;
        // R2 fetched word, zero past flash top
        st_d.instr = gated_word;
        unique case (st_q.mode)
            pmv_pkg::PMV_RUN:
            begin
                if (sleep_req_in)
                    st_d.mode = pmv_pkg::PMV_SLEEP;
                else if (step_in)
                    st_d.pc = st_q.pc + pmv_pkg::PC_STEP;
            end
            pmv_pkg::PMV_SLEEP:
            begin
                if (wake)
                begin
                    st_d.mode = pmv_pkg::PMV_RUN;
                    // R6 vector only with a global enable
                    if (high_prio_global_irq_enable_in || low_prio_global_irq_enable_in)
                    begin
                        // R10 high priority takes 0008h
                        // R5 two fixed vectors
                        st_d.pc = any_high ? pmv_pkg::HIGH_VEC : pmv_pkg::LOW_VEC;
                        // R7 push return address
                        st_d.tos = st_q.pc;
                        st_d.sp = st_q.sp + pmv_pkg::SP_STEP;
                    end
                end
            end
            default:
                st_d.mode = pmv_pkg::PMV_RUN;
        endcase
    end

    // State register; R4 PC starts at reset vector
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            st_q <= '0;
            st_q.mode <= pmv_pkg::PMV_RUN;
            st_q.pc <= pmv_pkg::RESET_VEC;
            st_q.sp <= pmv_pkg::SP_RESET;
        end
        else
            st_q <= st_d;
    end

    // R1 full 21-bit address out
    assign prog_addr_out = st_q.pc;
    assign instr_out = st_q.instr;
    assign data_addr_out = st_q.daddr;
    assign data_rd_out = st_q.drd;
    assign sleeping_out = (st_q.mode == pmv_pkg::PMV_SLEEP);
    assign stack_top_upper_byte_out = {3'h0, st_q.tos[20:16]};
    assign stack_top_high_byte_out = st_q.tos[15:8];
    assign stack_top_low_byte_out = st_q.tos[7:0];
    assign hw_stack_pointer_out = st_q.sp;
    assign peripheral_irq_flag_regs_out = st_q.flags;

    // ------------------------------
    // Assertions
    // ------------------------------
    property p_reset_vec;
        @(posedge clk_in) $rose(reset_n_in) |-> st_q.pc == pmv_pkg::RESET_VEC;
    endproperty
    a_reset_vec: assert property (p_reset_vec) else $error("pc not zero after reset"); // R4

    property p_high_vec;
        @(posedge clk_in) disable iff (!reset_n_in)
        (wake && any_high && high_prio_global_irq_enable_in) |=> st_q.pc == pmv_pkg::HIGH_VEC;
    endproperty
    a_high_vec: assert property (p_high_vec) else $error("high vector not loaded"); // R10

    property p_low_vec;
        @(posedge clk_in) disable iff (!reset_n_in)
        (wake && !any_high && low_prio_global_irq_enable_in) |=> st_q.pc == pmv_pkg::LOW_VEC;
    endproperty
    a_low_vec: assert property (p_low_vec) else $error("low vector not loaded"); // R5

    property p_push;
        @(posedge clk_in) disable iff (!reset_n_in)
        (wake && (high_prio_global_irq_enable_in || low_prio_global_irq_enable_in))
        |=> st_q.tos == $past(st_q.pc) && st_q.sp == $past(st_q.sp) + pmv_pkg::SP_STEP;
    endproperty
    a_push: assert property (p_push) else $error("stack push wrong"); // R7

    property p_no_vec;
        @(posedge clk_in) disable iff (!reset_n_in)
        (wake && !high_prio_global_irq_enable_in && !low_prio_global_irq_enable_in)
        |=> st_q.sp == $past(st_q.sp) && st_q.pc == $past(st_q.pc);
    endproperty
    a_no_vec: assert property (p_no_vec) else $error("vectored without enable"); // R6

    property p_nop;
        @(posedge clk_in) disable iff (!reset_n_in)
        (st_q.pc >= FLASH_TOP) |=> instr_out == pmv_pkg::NOP_WORD;
    endproperty
    a_nop: assert property (p_nop) else $error("fetch past flash not zero"); // R2

    property p_inrange;
        @(posedge clk_in) disable iff (!reset_n_in)
        (st_q.pc < FLASH_TOP) |=> instr_out == $past(prog_data_in);
    endproperty
    a_inrange: assert property (p_inrange) else $error("flash word lost"); // R3

    property p_flag;
        @(posedge clk_in) disable iff (!reset_n_in)
        (irq_req_in != '0)
        |=> (peripheral_irq_flag_regs_out & $past(irq_req_in)) == $past(irq_req_in);
    endproperty
    a_flag: assert property (p_flag) else $error("wake flag not set"); // R8

    property p_data;
        @(posedge clk_in) disable iff (!reset_n_in)
        data_rd_in |=> data_rd_out && data_addr_out == $past(data_addr_in);
    endproperty
    a_data: assert property (p_data) else $error("data access blocked"); // R9

    property p_step;
        @(posedge clk_in) disable iff (!reset_n_in)
        (!sleeping_out && step_in && !sleep_req_in)
        |=> prog_addr_out == $past(prog_addr_out) + pmv_pkg::PC_STEP;
    endproperty
    a_step: assert property (p_step) else $error("pc step wrong"); // R1

    c_wake_high: cover property (@(posedge clk_in) wake && any_high);
    c_wake_low: cover property (@(posedge clk_in) wake && !any_high);
    c_nop: cover property (@(posedge clk_in) st_q.pc >= FLASH_TOP);
endmodule

// ### core/pmv_pkg.sv
// Purpose: Shared constants for the program memory and vector block
// Assumes: Byte-addressed program space, 16-bit instruction words
// Notes: All offsets and vectors are byte addresses
package pmv_pkg;
    localparam int PC_W = 21;
    localparam int WORD_W = 16;
    localparam int DATA_ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int STACK_DEPTH = 31;
    localparam int SP_W = 5;
    localparam logic [20:0] RESET_VEC = 21'h000000;
    localparam logic [20:0] HIGH_VEC = 21'h000008;
    localparam logic [20:0] LOW_VEC = 21'h000018;
    localparam logic [20:0] PC_STEP = 21'h000002;
    localparam logic [20:0] FLASH_BYTES_SMALL = 21'h00C000;
    localparam logic [20:0] FLASH_BYTES_LARGE = 21'h010000;
    localparam int WORDS_SMALL = 24576;
    localparam int WORDS_LARGE = 32768;
    localparam logic [15:0] NOP_WORD = 16'h0000;
    localparam logic [4:0] SP_RESET = 5'h00;
    localparam logic [4:0] SP_STEP = 5'h01;
    typedef enum logic [1:0] {PMV_RUN, PMV_SLEEP} pmv_mode_e;
endpackage

// ### core/pmv_fetch_gate.sv
// Purpose: Gate a program fetch to the implemented flash range
// Assumes: Flash data arrives combinationally for the presented address
// Notes: Addresses past the flash top read as the all-zero word
`timescale 1ns/100ps
module pmv_fetch_gate #(
    parameter logic [20:0] FLASH_BYTES = pmv_pkg::FLASH_BYTES_LARGE
) (
    // Fetch address and raw flash data
    input wire logic [pmv_pkg::PC_W-1:0] addr_in,
    input wire logic [pmv_pkg::WORD_W-1:0] flash_data_in,
    // Gated word and range flag
    output logic [pmv_pkg::WORD_W-1:0] word_out,
    output logic in_range_out
);
    // Range compare against the implemented top
    always_comb
    begin
        in_range_out = (addr_in < FLASH_BYTES);
        word_out = in_range_out ? flash_data_in : pmv_pkg::NOP_WORD;
    end
endmodule

// ### verif/pmv_flash_model.sv
// Purpose: Flash program memory model facing the fetch port
// Assumes: Word read is combinational from the byte address
// Notes: Past the top it drives a nonzero pattern, never zeros
`timescale 1ns/100ps
module pmv_flash_model #(
    parameter logic [20:0] TOP = pmv_pkg::FLASH_BYTES_SMALL
) (
    // Fetch address
    input wire logic [pmv_pkg::PC_W-1:0] addr_in,
    // Word read back
    output logic [pmv_pkg::WORD_W-1:0] data_out
);
    always_comb
    begin
        data_out = {addr_in[15:1], 1'b1} ^ 16'h5A00;
        if (addr_in >= TOP)
            data_out = ~addr_in[15:0] | 16'h0001;
    end
endmodule

// ### verif/tb_top.sv
// Purpose: Self-checking bench for the program memory vector block
// Assumes: Small flash variant, eight interrupt sources
// Notes: Runs about 25000 cycles, mostly the walk to the flash top
`timescale 1ns/100ps
`define CHK(a, b, m) begin compares++; if ((a) !== (b)) begin err_total++; \
    $display("mismatch %0t %s", $time, m); end end
module tb_top;
    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic step_in = 1'b0;
    logic sleep_in = 1'b0;
    logic gh = 1'b0;
    logic gl = 1'b0;
    logic [7:0] req = 8'h00;
    logic [7:0] en = 8'h00;
    logic [7:0] hi = 8'h00;
    logic [7:0] clr = 8'h00;
    logic [11:0] d_addr = 12'h000;
    logic d_rd = 1'b0;
    logic [20:0] p_addr, pc, tos;
    logic [15:0] p_data, instr;
    logic [11:0] d_addr_o;
    logic d_rd_o, sleeping;
    logic [7:0] tu, th, tl, flags;
    logic [4:0] sp_o, sp;
    int err_total = 0;
    int compares = 0;
    int cycles = 0;
    pmv_core #(.LARGE_VARIANT(1'b0), .N_SRC(8)) dut_u (.clk_in(clk_in),
        .reset_n_in(reset_n_in), .step_in(step_in), .sleep_req_in(sleep_in),
        .high_prio_global_irq_enable_in(gh), .low_prio_global_irq_enable_in(gl),
        .irq_req_in(req), .irq_en_in(en), .irq_high_in(hi), .flag_clr_in(clr),
        .prog_addr_out(p_addr), .prog_data_in(p_data), .instr_out(instr),
        .data_addr_in(d_addr), .data_rd_in(d_rd), .data_addr_out(d_addr_o),
        .data_rd_out(d_rd_o), .sleeping_out(sleeping), .stack_top_upper_byte_out(tu),
        .stack_top_high_byte_out(th), .stack_top_low_byte_out(tl),
        .hw_stack_pointer_out(sp_o), .peripheral_irq_flag_regs_out(flags));
    pmv_flash_model #(.TOP(pmv_pkg::FLASH_BYTES_SMALL)) flash_u (.addr_in(p_addr),
        .data_out(p_data));
    // Clock, 50 ns period
    initial
    begin
        forever #25 clk_in = ~clk_in;
    end
    // Hang guard, well above the expected run
    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            err_total++;
            end_of_test();
        end
    end
    function automatic logic [15:0] word_at(input logic [20:0] a);
        return {a[15:1], 1'b1} ^ 16'h5A00;
    endfunction
    task automatic end_of_test();
        if (err_total == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk_state();
        `CHK(p_addr, pc, "pc")
        `CHK(sp_o, sp, "stack pointer")
        `CHK({tu, th, tl}, {3'b000, tos}, "stack top")
    endtask
    task automatic do_reset();
        reset_n_in <= 1'b0;
        repeat (6) @(posedge clk_in);
        reset_n_in <= 1'b1;
        {pc, tos, sp} = '0;
        @(posedge clk_in);
        #1;
        chk_state();
        `CHK(flags, 8'h00, "flags at reset")
    endtask
    // Fetch step with a data read in the same cycle
    task automatic t_step_data();
        @(posedge clk_in);
        step_in <= 1'b1;
        d_addr <= 12'hABC;
        d_rd <= 1'b1;
        @(posedge clk_in);
        step_in <= 1'b0;
        d_rd <= 1'b0;
        pc = pc + pmv_pkg::PC_STEP;
        #1;
        `CHK(p_addr, pc, "step")
        `CHK({d_rd_o, d_addr_o}, 13'h1ABC, "data port")
        @(posedge clk_in);
        #1;
        `CHK(instr, word_at(pc), "fetched word")
    endtask
    // Sleep, then wake on source 0
    task automatic t_wake(input logic h, input logic eh, input logic el,
                          input logic [20:0] vec);
        @(posedge clk_in);
        sleep_in <= 1'b1;
        @(posedge clk_in);
        {sleep_in, req, en, hi, gh, gl} <= {1'b0, 8'h01, 8'h01, {7'h00, h}, eh, el};
        #1;
        `CHK(sleeping, 1'b1, "asleep")
        @(posedge clk_in);
        req <= 8'h00;
        clr <= 8'h01;
        if (eh | el)
        begin
            tos = pc;
            pc = vec;
            sp = sp + pmv_pkg::SP_STEP;
        end
        #1;
        `CHK(sleeping, 1'b0, "awake")
        `CHK(flags, 8'h01, "wake flag")
        chk_state();
        @(posedge clk_in);
        clr <= 8'h00;
        #1;
        `CHK(flags, 8'h00, "flag clear")
        `CHK(instr, word_at(pc), "vector word")
    endtask
    // Masked source while asleep: no wake, no step, set beats a same-cycle clear
    task automatic t_masked();
        @(posedge clk_in);
        sleep_in <= 1'b1;
        @(posedge clk_in);
        {sleep_in, step_in, req, en, clr} <= {1'b0, 1'b1, 8'h02, 8'h00, 8'h02};
        @(posedge clk_in);
        {step_in, clr} <= {1'b0, 8'h00};
        #1;
        `CHK(sleeping, 1'b1, "masked source woke core")
        `CHK(p_addr, pc, "pc moved while asleep")
        `CHK(flags, 8'h02, "flag lost to clear")
        @(posedge clk_in);
        {req, clr} <= {8'h00, 8'h02};
        @(posedge clk_in);
        clr <= 8'h00;
        #1;
        `CHK(flags, 8'h00, "masked flag not cleared")
        `CHK(sleeping, 1'b1, "woke without source")
    endtask
    // Walk to the last flash word and one past it
    task automatic t_top();
        @(posedge clk_in);
        step_in <= 1'b1;
        repeat (24575) @(posedge clk_in);
        step_in <= 1'b0;
        #1;
        `CHK(p_addr, 21'h00BFFE, "last word address")
        @(posedge clk_in);
        #1;
        `CHK(instr, word_at(21'h00BFFE), "last word")
        @(posedge clk_in);
        step_in <= 1'b1;
        @(posedge clk_in);
        step_in <= 1'b0;
        #1;
        `CHK(p_addr, pmv_pkg::FLASH_BYTES_SMALL, "past top address")
        @(posedge clk_in);
        #1;
        `CHK(instr, pmv_pkg::NOP_WORD, "past top word")
    endtask
    // Main sequence
    initial
    begin
        do_reset();
        `CHK($bits(dut_u.prog_addr_out), 21, "pc width")
        t_step_data();
        t_wake(1'b1, 1'b1, 1'b0, pmv_pkg::HIGH_VEC);
        t_wake(1'b0, 1'b0, 1'b1, pmv_pkg::LOW_VEC);
        t_masked();
        t_wake(1'b1, 1'b0, 1'b0, 21'h000000);
        do_reset();
        t_top();
        end_of_test();
    end
endmodule
